/* File: logic/vrc_pkg.sv */
// Purpose: Shared constants for the voice recorder serial control block
// Assumes: 125 MHz system clock, classic Wishbone register access
// Notes: Serial frames are 16 bits, least significant bit first
//
// Overview of operation
// - Device is only ever a serial bus slave
// - Serial frames read and write internal registers
// - Interrupt plus read-only status register for handshake
// - Sample input on rise, change output on fall
// - Select low enables; select high ignores bus
// - Software picks one of four sample rates
// - Record time scales with chosen sample rate
// - Host addresses any of 1200 storage rows
// - Control bits power down stages individually
// - Host data valid before rise; LSB first
// - Output released when deselected; LSB first
// - Interrupt low on overflow/end, cleared next frame
// - Rate field 00=8k,01=6.4k,10=5.3k,11=4k
`default_nettype none

package vrc_pkg;

    // Clock and sample rates
    localparam int CLK_HZ = 125_000_000;
    localparam int RATE_8K_HZ = 8000;
    localparam int RATE_6K4_HZ = 6400;
    localparam int RATE_5K3_HZ = 5300;
    localparam int RATE_4K_HZ = 4000;
    localparam int DIV_8K_DEF = CLK_HZ / RATE_8K_HZ;
    localparam int DIV_6K4_DEF = CLK_HZ / RATE_6K4_HZ;
    localparam int DIV_5K3_DEF = CLK_HZ / RATE_5K3_HZ;
    localparam int DIV_4K_DEF = CLK_HZ / RATE_4K_HZ;
    localparam int DIV_W = 16;

    // Storage geometry: every row holds the same number of samples
    localparam int ROWS_DEF = 1200;
    localparam int SAMPLES_PER_ROW_DEF = 1600;
    localparam int ROW_W = 11;
    localparam int SMP_W = 11;

    // Rate select encodings
    typedef enum logic [1:0] {
        VRC_RATE_8K = 2'b00,
        VRC_RATE_6K4 = 2'b01,
        VRC_RATE_5K3 = 2'b10,
        VRC_RATE_4K = 2'b11
    } vrc_rate_t;

    // Serial frame layout
    localparam int FRAME_W = 16;
    localparam int CNT_W = 4;
    localparam int FR_WR_BIT = 0;
    localparam int FR_ADDR_LSB = 1;
    localparam int FR_ADDR_W = 3;
    localparam int FR_DATA_LSB = 4;
    localparam int DATA_W = 12;

    // Serial register indices
    localparam logic [2:0] SREG_CTRL = 3'h0;
    localparam logic [2:0] SREG_ROW = 3'h1;
    localparam logic [2:0] SREG_FLAGS = 3'h2;

    // Control register fields
    localparam int CTL_RATE_LO = 0;
    localparam int CTL_RATE_HI = 1;
    localparam int CTL_RUN = 2;
    localparam int CTL_PD_LSB = 3;
    localparam int PD_W = 8;
    localparam logic [DATA_W-1:0] CTRL_RST = 12'h000;

    // Flag bits
    localparam int FLG_OVF = 0;
    localparam int FLG_EOM = 1;

    // Interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_EOM = 1;
    localparam int IRQ_FRAME = 2;

    // Wishbone byte addresses
    localparam int WB_AW = 8;
    localparam logic [7:0] WB_IRQ_STAT = 8'h00;
    localparam logic [7:0] WB_IRQ_CLR = 8'h04;
    localparam logic [7:0] WB_IRQ_EN = 8'h08;
    localparam logic [7:0] WB_CTRL = 8'h0C;
    localparam logic [7:0] WB_ROW = 8'h10;
    localparam logic [7:0] WB_FLAGS = 8'h14;

endpackage : vrc_pkg

`default_nettype wire

/* File: logic/vrc_rate_if.sv */
// Purpose: Carries rate selection and sample tick between modules
// Assumes: Single clock domain
// Notes: ctl side drives selection, gen side returns the tick
`default_nettype none

interface vrc_rate_if;
    import vrc_pkg::*;
    vrc_rate_t rate_sel; // Chosen sample rate
    logic run;           // Counting enabled
    logic tick;          // One-cycle sample pulse
    modport gen (input rate_sel, input run, output tick);
    modport ctl (output rate_sel, output run, input tick);
endinterface : vrc_rate_if

`default_nettype wire

/* File: logic/vrc_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: The first stage feeds only the second stage
`default_nettype none

module vrc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q; // First stage, read only by q_o

    // Two stage capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : vrc_sync

`default_nettype wire

/* File: logic/vrc_rate_gen.sv */
// Purpose: Sample tick divider for the four selectable rates
// Assumes: Divider values at least two
// Notes: Counter restarts whenever run is low
`default_nettype none

module vrc_rate_gen
    import vrc_pkg::*;
#(
    parameter int DIV_8K = DIV_8K_DEF,
    parameter int DIV_6K4 = DIV_6K4_DEF,
    parameter int DIV_5K3 = DIV_5K3_DEF,
    parameter int DIV_4K = DIV_4K_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    vrc_rate_if.gen rif
);
    logic [DIV_W-1:0] cnt_q;  // Cycles since last tick
    logic [DIV_W-1:0] last_w; // Terminal count for chosen rate
    logic tick_q;             // Registered tick

    // Rate field decode
    always_comb begin
        case (rif.rate_sel)
            VRC_RATE_8K: last_w = DIV_W'(DIV_8K - 1);
            VRC_RATE_6K4: last_w = DIV_W'(DIV_6K4 - 1);
            VRC_RATE_5K3: last_w = DIV_W'(DIV_5K3 - 1);
            VRC_RATE_4K: last_w = DIV_W'(DIV_4K - 1);
            default: last_w = DIV_W'(DIV_8K - 1);
        endcase
    end

    // Divider producing one pulse per sample period
    always_ff @(posedge clk_i) begin
        if (rst_i || !rif.run) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q >= last_w) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign rif.tick = tick_q;

    // Tick spacing matches the 8 kHz period
    rate_8k_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick_q && $past(rif.rate_sel) == VRC_RATE_8K
         && $past(rif.rate_sel, 2) == VRC_RATE_8K)
        |-> $past(cnt_q) == DIV_W'(DIV_8K - 1)
        ) else $error("8 kHz period wrong");
    tick_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_q |-> $past(cnt_q) >= $past(last_w) && $past(rif.run)
        ) else $error("tick without terminal count");
endmodule : vrc_rate_gen

`default_nettype wire

/* File: logic/vrc_top.sv */
// Purpose: Serial control port with Wishbone interrupt registers
// Assumes: Serial pins asynchronous; sclk much slower than clk_i
// Notes: Serial side writes settings; Wishbone sees mirrors and IRQs
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`default_nettype none

module vrc_top
    import vrc_pkg::*;
#(
    parameter int DIV_8K = DIV_8K_DEF,
    parameter int DIV_6K4 = DIV_6K4_DEF,
    parameter int DIV_5K3 = DIV_5K3_DEF,
    parameter int DIV_4K = DIV_4K_DEF,
    parameter int ROWS = ROWS_DEF,
    parameter int SAMPLES_PER_ROW = SAMPLES_PER_ROW_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // Serial pins
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic ss_n_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic int_n_o,
    output logic int_oe_o,
    // Core side
    input wire logic eom_i,
    output logic [1:0] rate_sel_o,
    output logic [PD_W-1:0] power_down_o,
    output logic [ROW_W-1:0] row_addr_o,
    output logic sample_tick_o
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    ////////////////////////////////////////////////////////////////////
    logic sclk_s;  // Synchronised serial clock
    logic mosi_s;  // Synchronised data in
    logic ss_n_s;  // Synchronised select, low active
    logic sclk_p;  // Previous serial clock level
    logic sclk_rise; // Rising edge seen
    logic sclk_fall; // Falling edge seen

    vrc_sync #(.W(1), .RST_VAL(1'b0)) u_sync_sclk (
        .clk_i(clk_i), .rst_i(rst_i), .d_i(sclk_i), .q_o(sclk_s));
    vrc_sync #(.W(1), .RST_VAL(1'b0)) u_sync_mosi (
        .clk_i(clk_i), .rst_i(rst_i), .d_i(mosi_i), .q_o(mosi_s));
    vrc_sync #(.W(1), .RST_VAL(1'b1)) u_sync_ss (
        .clk_i(clk_i), .rst_i(rst_i), .d_i(ss_n_i), .q_o(ss_n_s));

    // Edge finder on the synchronised clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_p <= 1'b0;
        end else begin
            sclk_p <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_p && !ss_n_s;
    assign sclk_fall = !sclk_s && sclk_p && !ss_n_s;

    ////////////////////////////////////////////////////////////////////
    // Serial shift engine
    ////////////////////////////////////////////////////////////////////
    logic [FRAME_W-1:0] rx_q;   // Incoming shift register
    logic [FRAME_W-1:0] tx_q;   // Outgoing shift register
    logic [FRAME_W-1:0] reply_q; // Word for the next frame
    logic [FRAME_W-1:0] word_w; // Completed frame
    logic [CNT_W-1:0] bit_cnt_q; // Bits taken in this frame
    logic ss_n_p;               // Previous select level
    logic frame_done;           // Last bit of a frame taken
    logic frame_start;          // Select just asserted
    logic miso_q;
    logic miso_oe_q;

    assign word_w = {mosi_s, rx_q[FRAME_W-1:1]};
    assign frame_start = ss_n_p && !ss_n_s;
    assign frame_done = sclk_rise && (bit_cnt_q == CNT_W'(FRAME_W - 1));

    // Select history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ss_n_p <= 1'b1;
        end else begin
            ss_n_p <= ss_n_s;
        end
    end

    // Receive: sample on rise, LSB arrives first
    always_ff @(posedge clk_i) begin
        if (rst_i || ss_n_s) begin
            rx_q <= '0;
            bit_cnt_q <= '0;
        end else if (sclk_rise) begin
            rx_q <= word_w;
            bit_cnt_q <= frame_done ? '0 : bit_cnt_q + 1'b1;
        end
    end

    // Transmit: load at select, change only on fall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_q <= '0;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else if (ss_n_s) begin
            miso_oe_q <= 1'b0;
            miso_q <= 1'b0;
        end else if (frame_start) begin
            tx_q <= reply_q;
            miso_q <= reply_q[0];
            miso_oe_q <= 1'b1;
        end else if (sclk_fall) begin
            tx_q <= {1'b0, tx_q[FRAME_W-1:1]};
            miso_q <= tx_q[1];
        end
    end

    assign miso_o = miso_q;
    assign miso_oe_o = miso_oe_q;

    ////////////////////////////////////////////////////////////////////
    // Serial register file
    ////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] ctrl_q;    // Rate, run, power-down
    logic [ROW_W-1:0] row_q;      // Current row
    logic [SMP_W-1:0] smp_q;      // Samples within row
    logic [1:0] flags_q;          // Overflow, end-of-message
    logic fr_wr;
    logic [FR_ADDR_W-1:0] fr_addr;
    logic [DATA_W-1:0] fr_data;
    logic ovf_evt;                // Last row filled
    logic eom_evt;                // End marker from core
    logic row_end;                // Last sample of a row
    logic [DATA_W-1:0] rd_val;    // Register addressed by frame
    vrc_rate_if rif ();

    assign fr_wr = word_w[FR_WR_BIT];
    assign fr_addr = word_w[FR_ADDR_LSB +: FR_ADDR_W];
    assign fr_data = word_w[FR_DATA_LSB +: DATA_W];
    assign row_end = rif.tick && (smp_q == SMP_W'(SAMPLES_PER_ROW - 1));
    assign ovf_evt = row_end && (row_q == ROW_W'(ROWS - 1));
    assign eom_evt = eom_i && ctrl_q[CTL_RUN];

    // Control register: serial writes, hardware stops run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
        end else if (frame_done && fr_wr && fr_addr == SREG_CTRL) begin
            ctrl_q <= fr_data;
        end else if (ovf_evt || eom_evt) begin
            ctrl_q[CTL_RUN] <= 1'b0;
        end
    end

    // Row and sample position; row address loaded by host
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_q <= '0;
            smp_q <= '0;
        end else if (frame_done && fr_wr && fr_addr == SREG_ROW) begin
            row_q <= fr_data[ROW_W-1:0] >= ROW_W'(ROWS) ?
                     ROW_W'(ROWS - 1) : fr_data[ROW_W-1:0];
            smp_q <= '0;
        end else if (row_end) begin
            smp_q <= '0;
            row_q <= ovf_evt ? row_q : row_q + 1'b1;
        end else if (rif.tick) begin
            smp_q <= smp_q + 1'b1;
        end
    end

    // Flags: cleared by a completed frame, a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= '0;
        end else begin
            flags_q[FLG_OVF] <= ovf_evt ||
                (flags_q[FLG_OVF] && !frame_done);
            flags_q[FLG_EOM] <= eom_evt ||
                (flags_q[FLG_EOM] && !frame_done);
        end
    end

    // Read mux; flags register ignores writes
    always_comb begin
        case (fr_addr)
            SREG_CTRL: rd_val = ctrl_q;
            SREG_ROW: rd_val = DATA_W'(row_q);
            SREG_FLAGS: rd_val = DATA_W'(flags_q);
            default: rd_val = '0;
        endcase
    end

    // Reply for the next frame captured at completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reply_q <= '0;
        end else if (frame_done) begin
            reply_q <= {rd_val, fr_addr, 1'b0};
        end
    end

    // Interrupt pin: pulled low on event, released by next frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_oe_o <= 1'b0;
            int_n_o <= 1'b1;
        end else begin
            int_oe_o <= ovf_evt || eom_evt || (int_oe_o && !frame_done);
            int_n_o <= !(ovf_evt || eom_evt ||
                         (int_oe_o && !frame_done));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Rate generator and core outputs
    ////////////////////////////////////////////////////////////////////
    assign rif.rate_sel = vrc_rate_t'({ctrl_q[CTL_RATE_HI],
                                      ctrl_q[CTL_RATE_LO]});
    assign rif.run = ctrl_q[CTL_RUN];

    vrc_rate_gen #(
        .DIV_8K(DIV_8K),
        .DIV_6K4(DIV_6K4),
        .DIV_5K3(DIV_5K3),
        .DIV_4K(DIV_4K)
    ) u_rate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rif(rif)
    );

    // Registered copies for the analog core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_sel_o <= '0;
            power_down_o <= '0;
            row_addr_o <= '0;
            sample_tick_o <= 1'b0;
        end else begin
            rate_sel_o <= {ctrl_q[CTL_RATE_HI], ctrl_q[CTL_RATE_LO]};
            power_down_o <= ctrl_q[CTL_PD_LSB +: PD_W];
            row_addr_o <= row_q;
            sample_tick_o <= rif.tick;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave and interrupt registers
    ////////////////////////////////////////////////////////////////////
    logic [IRQ_W-1:0] irq_stat_q; // Sticky events
    logic [IRQ_W-1:0] irq_en_q;   // Enable mask
    logic [IRQ_W-1:0] irq_evt;    // Events this cycle
    logic [IRQ_W-1:0] irq_clr;    // Clear strobe bits
    logic wb_req;                 // New request this cycle
    logic wb_wr;                  // Write to low byte

    assign irq_evt = {frame_done, eom_evt, ovf_evt};
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    assign irq_clr = (wb_wr && wb_adr_i == WB_IRQ_CLR) ?
                     wb_dat_i[IRQ_W-1:0] : '0;

    // One-cycle acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Read data; unmapped and write-only read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                WB_IRQ_STAT: wb_dat_o <= 32'(irq_stat_q);
                WB_IRQ_EN: wb_dat_o <= 32'(irq_en_q);
                WB_CTRL: wb_dat_o <= 32'(ctrl_q);
                WB_ROW: wb_dat_o <= 32'(row_q);
                WB_FLAGS: wb_dat_o <= 32'(flags_q);
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // Enable mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= '0;
        end else if (wb_wr && wb_adr_i == WB_IRQ_EN) begin
            irq_en_q <= wb_dat_i[IRQ_W-1:0];
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_q <= irq_evt | (irq_stat_q & ~irq_clr);
            irq_o <= |(irq_stat_q & irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    miso_release_a: assert property (
        ss_n_s |=> !miso_oe_o) else $error("miso driven while idle");
    miso_fall_a: assert property (
        (miso_oe_o && $past(miso_oe_o) && $changed(miso_o))
        |-> $past(sclk_fall)) else $error("miso moved off falling edge");
    bit_count_a: assert property (
        (sclk_rise && !frame_done) |=> bit_cnt_q == $past(bit_cnt_q) + 1'b1
        ) else $error("bit not counted on rise");
    idle_ignore_a: assert property (
        ss_n_s |=> bit_cnt_q == '0 && $stable(ctrl_q[CTL_PD_LSB +: PD_W])
        ) else $error("activity while deselected");
    int_set_a: assert property (
        (ovf_evt || eom_evt) |=> (int_oe_o && !int_n_o)
        ) else $error("interrupt not asserted");
    int_clear_a: assert property (
        (frame_done && !ovf_evt && !eom_evt) |=> !int_oe_o && int_n_o
        ) else $error("interrupt not released");
    flags_ro_a: assert property (
        (frame_done && fr_wr && fr_addr == SREG_FLAGS && !ovf_evt
         && !eom_evt && !rif.tick) |=> $stable(ctrl_q) && $stable(row_q)
        ) else $error("read-only register changed state");
    ovf_stop_a: assert property (
        (ovf_evt && !(frame_done && fr_wr)) |=> !ctrl_q[CTL_RUN]
        ) else $error("run not stopped at overflow");
    irq_level_a: assert property (
        (|(irq_stat_q & irq_en_q)) |=> irq_o) else $error("irq not raised");
    wb_ack_a: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

    frame_c: cover property (frame_done && fr_wr);
    overflow_c: cover property (ovf_evt);
    int_cycle_c: cover property (int_oe_o ##[1:200] !int_oe_o);
endmodule : vrc_top

`default_nettype wire

/* File: tb/vrc_host_model.sv */
// Purpose: Behavioural SPI host for the serial control port
// Assumes: clk_i at 125 MHz; sclk period 160 ns (20 clocks)
// Notes: All lines change just after clk_i rising edges
`default_nettype none

module vrc_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic ss_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: clock low, deselected
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end

    // Half an sclk period
    task automatic half;
        repeat (10) @(posedge clk_i);
    endtask : half

    // Frame of n bits LSB first; sel low keeps select high
    task automatic xfer(input logic [15:0] tx, input int n,
                        input logic sel, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk_i);
        ss_n_o <= ~sel;
        half();
        for (int i = 0; i < n; i++) begin
            mosi_o <= tx[i];
            half();
            sclk_o <= 1'b1;
            rx[i] = miso_i;
            half();
            sclk_o <= 1'b0;
        end
        half();
        ss_n_o <= 1'b1;
        // Released line must not keep the last bit
        mosi_o <= ~mosi_o;
        half();
    endtask : xfer
endmodule : vrc_host_model

`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the serial control port
// Assumes: Short divider and geometry parameters
// Notes: Wishbone tasks drive every test, serial host tasks all but the reset test; events test also drives end_of_message_flag
`default_nettype none

module testbench;
    import vrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i, rst_i, cyc, stb, we, end_of_message_flag;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dato;
    logic ack, irq, miso, miso_oe, int_n, int_oe, tick;
    logic sclk, mosi, ss_n;
    logic [1:0] rate;
    logic [PD_W-1:0] pd;
    logic [ROW_W-1:0] row;
    logic [15:0] rx;
    logic [11:0] d;
    int error_cnt, compares, cycles, t;
    // Wire levels: released miso shows the inverse, int pulled up
    wire logic miso_w = miso_oe ? miso : ~miso;
    wire logic int_w = int_oe ? 1'b0 : 1'b1;

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    vrc_top #(.DIV_8K(4), .DIV_5K3(6), .DIV_4K(8),
        .ROWS(4), .SAMPLES_PER_ROW(4)) vrc_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dato), .wb_ack_o(ack), .irq_o(irq), .sclk_i(sclk),
        .mosi_i(mosi), .ss_n_i(ss_n), .miso_o(miso), .miso_oe_o(miso_oe),
        .int_n_o(int_n), .int_oe_o(int_oe), .eom_i(end_of_message_flag),
        .rate_sel_o(rate), .power_down_o(pd), .row_addr_o(row),
        .sample_tick_o(tick));

    vrc_host_model vrc_host_model_inst (.clk_i(clk_i), .miso_i(miso_w),
        .sclk_o(sclk), .mosi_o(mosi), .ss_n_o(ss_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic Wishbone cycle; read data lands in rdat
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rdat = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // Full serial frame {data, addr, write}
    task automatic fr(input logic [11:0] v, input logic [2:0] a,
                      input logic w);
        vrc_host_model_inst.xfer({v, a, w}, 16, 1'b1, rx);
    endtask : fr

    task automatic finish_test;
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    // Hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        {rst_i, cyc, stb, we, end_of_message_flag} = 5'h10;
        {adr, wdat, sel} = {8'h00, 32'h0, 4'hF};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, WB_IRQ_STAT, 0); chk(rdat, 0);
        chk({miso_oe, int_w, irq}, 3'h2);
        wb(0, 8'h20, 0); chk(rdat, 0);
        wb(1, WB_IRQ_STAT, 7); wb(0, WB_IRQ_STAT, 0); chk(rdat, 0);
        wb(1, WB_IRQ_EN, 7); wb(0, WB_IRQ_EN, 0); chk(rdat, 7);
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            d = {1'b0, 8'hA5 ^ 8'(r), 1'b0, 2'(r)};
            fr(d, SREG_CTRL, 1);
            chk(rate, r);
            chk(pd, 8'hA5 ^ 8'(r));
            wb(0, WB_CTRL, 0); chk(rdat, d);
            fr(0, SREG_CTRL, 0);
            fr(0, SREG_CTRL, 0);
            chk(rx, {d, 4'h0});
        end
        chk(irq, 1);
        wb(1, WB_IRQ_EN, 0); wb(1, WB_IRQ_CLR, 7); fr(0, SREG_CTRL, 0);
        repeat (2) @(posedge clk_i);
        chk(irq, 0);
        wb(0, WB_IRQ_STAT, 0); chk(rdat, 4);
        wb(1, WB_IRQ_EN, 7); repeat (2) @(posedge clk_i); chk(irq, 1);
        $display("test rate and irq done");
        vrc_host_model_inst.xfer(16'h0001, 8, 1'b1, rx);
        vrc_host_model_inst.xfer(16'h0001, 16, 1'b0, rx);
        chk(rate, 3);
        fr(12'd1500, SREG_ROW, 1); chk(row, 3);
        fr(12'd2, SREG_ROW, 1);
        wb(0, WB_ROW, 0);
        chk(row, 2);
        chk(rdat, 2);
        fr(12'hFFF, SREG_FLAGS, 1);
        wb(0, WB_ROW, 0);
        chk(rdat, 2);
        wb(0, WB_FLAGS, 0);
        chk(rdat, 0);
        $display("test select and row done");
        fr(0, SREG_ROW, 1);
        fr(12'h004, SREG_CTRL, 1);
        while (tick !== 1'b1) @(posedge clk_i);
        t = cycles;
        @(posedge clk_i);
        while (tick !== 1'b1) @(posedge clk_i);
        chk(cycles - t, 4);
        @(posedge clk_i); end_of_message_flag <= 1'b1;
        @(posedge clk_i); end_of_message_flag <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(int_w, 0);
        wb(0, WB_FLAGS, 0); chk(rdat, 2);
        fr(0, SREG_FLAGS, 0); chk(int_w, 1);
        sel <= 4'h0;
        wb(1, WB_IRQ_CLR, 7);
        sel <= 4'hF;
        wb(0, WB_IRQ_STAT, 0);
        chk(rdat[1:0], 2);
        wb(1, WB_IRQ_CLR, 7);
        fr(0, SREG_ROW, 1); fr(12'h007, SREG_CTRL, 1);
        while (tick !== 1'b1) @(posedge clk_i);
        t = cycles;
        @(posedge clk_i);
        while (tick !== 1'b1) @(posedge clk_i);
        chk(cycles - t, 8);
        while (int_w !== 1'b0) @(posedge clk_i);
        wb(0, WB_CTRL, 0); chk(rdat, 3);
        wb(0, WB_IRQ_STAT, 0); chk(rdat[1:0], 1);
        fr(0, SREG_FLAGS, 0); chk(int_w, 1);
        fr(0, SREG_CTRL, 0); chk(rx, 16'h0014);
        $display("test events done");
        finish_test();
    end
endmodule : testbench

`default_nettype wire
